/* File: hdl/stta_arbiter.sv */
// Two-tier rotational arbiter of the secondary bus, with its control register.
// Assumes requests and bus_idle synchronous to mclk; config accesses are
// single-cycle strobes from the bridge's configuration space.
//
// How it works
// - Round-robin grant within two priority tiers
// - Control register resets to 40h
// - Park bit one parks bus on bridge
// - Park bit zero parks on last owner
// - Bit 6 sets the bridge tier
// - Bits 5..0 set external master tiers
// - All eight bits read/write, reset 40h
`timescale 1ns/1ps
`default_nettype none
`include "stta_params.svh"

module stta_arbiter
  import stta_pkg::*;
#(
  parameter int N_EXT = `STTA_N_EXT
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic bus_idle,
  input wire logic bridge_req,
  input wire logic [N_EXT-1:0] ext_req,
  output logic bridge_gnt,
  output logic [N_EXT-1:0] ext_gnt
);
  // The register has exactly six external tier bits
  if (N_EXT != `STTA_N_EXT) begin : g_bad_n_ext
    $error("stta_arbiter supports six masters");
  end

  logic [7:0] ctrl_q; // arbiter_control
  logic [7:0] ctrl_d;
  logic [7:0] rdata_q; // Registered read data
  logic [7:0] rdata_d;
  stta_vec_t grant_q; // Current grant, one-hot or zero
  stta_vec_t grant_d;
  stta_vec_t owner_q; // Master that last used the bus
  stta_vec_t owner_d;
  logic idle_q; // Bus idle one cycle ago
  stta_vec_t req; // All requests, bridge at bit 6
  stta_vec_t tier; // One means high tier
  stta_vec_t hi_req;
  stta_vec_t lo_req;
  logic [7:0] hi_win; // High rotation, slot 7 is the low tier
  stta_vec_t lo_win;
  stta_vec_t winner;
  logic taken; // Bus went busy under the grant
  stta_park_t park_mode;

  assign req = {bridge_req, ext_req};
  assign tier = ctrl_q[`STTA_BRIDGE_BIT:0];
  assign hi_req = req & tier;
  assign lo_req = req & ~tier;
  assign park_mode = stta_park_t'(ctrl_q[`STTA_PARK_BIT]);
  assign taken = idle_q && !bus_idle && (grant_q != '0);

  // Register writes and reads through configuration space
  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    if (cfg_wr_en && cfg_addr == `STTA_CTRL_OFFSET) begin
      ctrl_d = cfg_wdata;
    end
    if (cfg_rd_en) begin
      // Unmapped offsets read zero here
      rdata_d = (cfg_addr == `STTA_CTRL_OFFSET) ? ctrl_q : 8'h00;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `STTA_CTRL_RESET;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign cfg_rdata = rdata_q;

  // High tier: members plus one shared slot for the whole low tier
  stta_rr #(.N(8)) u_hi_rr (
    .mclk(mclk),
    .reset_n(reset_n),
    .req({|lo_req, hi_req}),
    .upd(taken),
    .upd_vec(((grant_q & ~tier) != '0) ? 8'h80 : {1'b0, grant_q}),
    .win(hi_win)
  );

  // Low tier rotates among its own members
  stta_rr #(.N(`STTA_N_EXT + 1)) u_lo_rr (
    .mclk(mclk),
    .reset_n(reset_n),
    .req(lo_req),
    .upd(taken && ((grant_q & ~tier) != '0)),
    .upd_vec(grant_q),
    .win(lo_win)
  );

  // Low tier wins only when its slot comes round
  assign winner = hi_win[`STTA_LO_SLOT] ? lo_win
                  : hi_win[`STTA_BRIDGE_BIT:0];

  // Grant moves only while the bus is idle, so an owner is never cut off
  always_comb begin
    grant_d = grant_q;
    owner_d = owner_q;
    if (!bus_idle && grant_q != '0) begin
      owner_d = grant_q; // Remember who is using the bus
    end
    if (bus_idle) begin
      if (req != '0) begin
        grant_d = winner;
      end else if (park_mode == stta_park_bridge) begin
        grant_d = stta_vec_t'(1) << `STTA_BRIDGE_BIT;
      end else begin
        grant_d = owner_q;
      end
    end
  end

  // Bridge is the owner before any transfer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      grant_q <= '0;
      owner_q <= stta_vec_t'(1) << `STTA_BRIDGE_BIT;
      idle_q <= 1'b1;
    end else begin
      grant_q <= grant_d;
      owner_q <= owner_d;
      idle_q <= bus_idle;
    end
  end

  assign bridge_gnt = grant_q[`STTA_BRIDGE_BIT];
  assign ext_gnt = grant_q[N_EXT-1:0];

  // Helper: high only in the first cycle after reset release
  logic first_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) first_q <= 1'b1;
    else first_q <= 1'b0;
  end

  // Helper: tiers as they stood when the last grant was taken
  // A tier write during a transfer would leave the pointers out of step
  stta_vec_t tier_take_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) tier_take_q <= stta_vec_t'(`STTA_CTRL_RESET);
    else if (taken) tier_take_q <= tier;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Register starts at its reset pattern
  a_ctrl_reset: assert property (first_q |-> ctrl_q == 8'h40)
    else $error("control register not 40h after reset");
  // Write lands and reads back two cycles later
  a_ctrl_write: assert property (
    (cfg_wr_en && cfg_addr == 8'hdc) ##1 (cfg_rd_en && cfg_addr == 8'hdc
      && !cfg_wr_en) |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("control write did not read back");
  // Writes to other offsets leave the register alone
  a_ctrl_refuse: assert property (
    (cfg_wr_en && cfg_addr != 8'hdc) |=> $stable(ctrl_q))
    else $error("foreign write changed control register");
  // Read data stands until the next read strobe
  a_rdata_hold: assert property (!cfg_rd_en |=> $stable(cfg_rdata))
    else $error("read data moved without a read");
  // Never two grants
  a_grant_onehot: assert property ($onehot0(grant_q))
    else $error("more than one grant");
  // A requester wins whenever any requests on an idle bus
  a_req_wins: assert property (
    (bus_idle && req != '0) |=> (grant_q & $past(req)) != '0)
    else $error("idle bus not granted to a requester");
  // Busy bus keeps its grant
  a_hold_busy: assert property (!bus_idle |=> $stable(grant_q))
    else $error("grant moved while bus busy");
  // Parking on the bridge
  a_park_bridge: assert property (
    (bus_idle && req == '0 && ctrl_q[7]) |=> grant_q == 7'h40)
    else $error("idle bus not parked on bridge");
  // Parking on the last owner
  a_park_last: assert property (
    (bus_idle && req == '0 && !ctrl_q[7]) |=> grant_q == $past(owner_q))
    else $error("idle bus not parked on last owner");
  // Lone bridge request wins in either tier
  a_bridge_alone: assert property (
    (bus_idle && req == 7'h40) |=> bridge_gnt && ext_gnt == '0)
    else $error("lone bridge request not granted");
  // With no high-tier request, a low-tier member wins
  a_low_only: assert property (
    (bus_idle && hi_req == '0 && lo_req != '0)
      |=> (grant_q & ~$past(tier)) != '0)
    else $error("low tier not served");
  // After a high-tier transfer another high requester goes next
  a_hi_rotate: assert property (
    ($rose(bus_idle) && tier == tier_take_q && (owner_q & tier) != '0
      && (hi_req & ~owner_q) != '0 && lo_req == '0)
      |=> grant_q != $past(owner_q))
    else $error("high tier did not rotate");

  c_park_bridge: cover property (bus_idle && req == '0 && ctrl_q[7]);
  c_low_slot: cover property (taken && (grant_q & ~tier) != '0);
  c_hi_pair: cover property (bus_idle && $countones(hi_req) >= 2);
  c_hi_turn: cover property (
    $rose(bus_idle) && (owner_q & tier) != '0 && (hi_req & ~owner_q) != '0);
endmodule : stta_arbiter

`default_nettype wire

/* File: hdl/stta_params.svh */
// Constants of the two-tier secondary bus arbiter.
// Included by bare name; definitions only.
`ifndef STTA_PARAMS_SVH
`define STTA_PARAMS_SVH

// Configuration offset of arbiter_control
`define STTA_CTRL_OFFSET 8'hdc
// Reset value of arbiter_control
`define STTA_CTRL_RESET 8'h40
// Idle-owner select bit
`define STTA_PARK_BIT 7
// Bridge tier bit, also bridge index in request vectors
`define STTA_BRIDGE_BIT 6
// Number of external masters
`define STTA_N_EXT 6
// Slot index of the low tier inside the high-tier rotation
`define STTA_LO_SLOT 7

`endif

/* File: hdl/stta_pkg.sv */
// Types shared by the two-tier secondary bus arbiter.
// Assumes stta_params.svh is on the include path.
`include "stta_params.svh"

package stta_pkg;
  // One bit per master: external 5..0 plus the bridge at bit 6
  typedef logic [`STTA_N_EXT:0] stta_vec_t;
  // Where the idle bus is left
  typedef enum logic {stta_park_last, stta_park_bridge} stta_park_t;
endpackage : stta_pkg

/* File: hdl/stta_rr.sv */
// Round-robin picker: rotating priority after the last recorded winner.
// Assumes one clock, async active-low reset; win is combinational.
`timescale 1ns/1ps
`default_nettype none

module stta_rr #(
  parameter int N = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [N-1:0] req,
  input wire logic upd,
  input wire logic [N-1:0] upd_vec,
  output logic [N-1:0] win
);
  localparam int IW = $clog2(N);

  // A one-entry rotation makes no sense
  if (N < 2) begin : g_bad_n
    $error("stta_rr needs N >= 2");
  end

  logic [IW-1:0] last_q; // Index of the last taken winner
  logic [IW-1:0] last_d;

  // Search from the entry after the last winner, wrapping round
  always_comb begin
    int idx;
    logic found;
    idx = 0;
    found = 1'b0;
    win = '0;
    for (int k = 1; k <= N; k++) begin
      idx = (int'(last_q) + k) % N;
      if (!found && req[idx]) begin
        win[idx] = 1'b1;
        found = 1'b1;
      end
    end
  end

  // Pointer moves only when a grant is really taken
  always_comb begin
    last_d = last_q;
    if (upd) begin
      for (int k = 0; k < N; k++) begin
        if (upd_vec[k]) last_d = IW'(k);
      end
    end
  end

  // Start just before entry 0
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) last_q <= IW'(N - 1);
    else last_q <= last_d;
  end
endmodule : stta_rr

`default_nettype wire

/* File: tb/stta_master_model.sv */
// Behavioural masters of the secondary bus: six external plus the bridge.
// Assumes grants come from the arbiter on mclk; one transfer at a time.
`timescale 1ns/1ps
`default_nettype none

module stta_master_model #(
  parameter int LEN = 3 // Busy cycles per transfer
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [6:0] want, // Requests asked by the bench
  input wire logic [6:0] gnt, // Bridge at bit 6
  output logic [6:0] req,
  output logic bus_idle
);
  logic [3:0] busy_q; // Cycles left of the running transfer
  logic [6:0] seen_q; // Grants held by requesters at the last edge

  // A grant must stand two edges, so a parked grant is not taken at once
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      req <= 7'h00;
      busy_q <= 4'h0;
      seen_q <= 7'h00;
    end else begin
      seen_q <= gnt & req;
      if (busy_q != 4'h0) begin
        busy_q <= busy_q - 4'h1;
      end else if ((gnt & req & seen_q) != 7'h00) begin
        req <= want & ~gnt;
        busy_q <= 4'(LEN);
      end else begin
        req <= want;
      end
    end
  end
  assign bus_idle = (busy_q == 4'h0); // Idle outside transfers
endmodule : stta_master_model
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench of the two-tier arbiter and its control register.
// Assumes the master model drives requests and bus activity.
`timescale 1ns/1ps
`default_nettype none
`include "stta_params.svh"

module tb;
  logic mclk = 1'b0; // 20 MHz clock
  logic reset_n = 1'b0; // Held low at start
  logic cfg_wr_en = 1'b0;
  logic cfg_rd_en = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata;
  logic bus_idle;
  logic bridge_gnt;
  logic [5:0] ext_gnt;
  logic [6:0] want = 7'h00; // Requests asked of the masters
  logic [6:0] req; // Requests as presented
  int errors = 0;
  int checks_done = 0;

  initial begin
    forever #25 mclk = ~mclk;
  end

  stta_arbiter #(.N_EXT(6)) dut_u (.mclk(mclk), .reset_n(reset_n),
    .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .bus_idle(bus_idle),
    .bridge_req(req[6]), .ext_req(req[5:0]), .bridge_gnt(bridge_gnt),
    .ext_gnt(ext_gnt));
  stta_master_model #(.LEN(3)) master_u (.mclk(mclk), .reset_n(reset_n),
    .want(want), .gnt({bridge_gnt, ext_gnt}), .req(req),
    .bus_idle(bus_idle));

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic conclude();
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // One-cycle write strobe, then a spacer cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr_en = 1'b1;
    @(negedge mclk);
    cfg_wr_en = 1'b0;
    @(negedge mclk);
  endtask : wr

  // Read data is settled one cycle after the strobe edge; spacer after
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cfg_addr = a;
    cfg_rd_en = 1'b1;
    @(negedge mclk);
    cfg_rd_en = 1'b0;
    check(cfg_rdata, exp);
    @(negedge mclk);
  endtask : rd

  // Write, then read in the very next cycle, then a spacer
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr_en = 1'b1;
    @(negedge mclk);
    cfg_wr_en = 1'b0;
    cfg_rd_en = 1'b1;
    @(negedge mclk);
    cfg_rd_en = 1'b0;
    check(cfg_rdata, d);
    @(negedge mclk);
  endtask : wr_rd

  // Request, check who took the bus, wait for it to go idle again
  task automatic grab(input logic [6:0] w, input logic [6:0] exp);
    int n;
    n = 0;
    want = w;
    while (bus_idle !== 1'b0 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    check({1'b0, bridge_gnt, ext_gnt}, {1'b0, exp});
    want = 7'h00;
    while (bus_idle !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 40) begin
      errors++;
      conclude();
    end
  endtask : grab

  // Reset value, all bits writable, other offsets refused
  task automatic t_regs();
    rd(`STTA_CTRL_OFFSET, `STTA_CTRL_RESET);
    rd(8'hd0, 8'h00);
    wr_rd(`STTA_CTRL_OFFSET, 8'h3c);
    wr(`STTA_CTRL_OFFSET, 8'hff);
    rd(`STTA_CTRL_OFFSET, 8'hff);
    wr(8'hdd, 8'h00);
    rd(`STTA_CTRL_OFFSET, 8'hff);
    wr(`STTA_CTRL_OFFSET, 8'h00);
    rd(`STTA_CTRL_OFFSET, 8'h00);
  endtask : t_regs

  // Bridge against master 2 with the tiers swapped
  task automatic t_tiers();
    wr(`STTA_CTRL_OFFSET, `STTA_CTRL_RESET);
    grab(7'h44, 7'h40);
    grab(7'h44, 7'h04);
    wr(`STTA_CTRL_OFFSET, 8'h04);
    grab(7'h44, 7'h04);
    grab(7'h44, 7'h40);
  endtask : t_tiers

  // Two low-tier masters take turns
  task automatic t_rotate();
    wr(`STTA_CTRL_OFFSET, 8'h00);
    grab(7'h12, 7'h02);
    grab(7'h12, 7'h10);
  endtask : t_rotate

  // Idle bus left on last owner, then on the bridge
  task automatic t_park();
    repeat (2) @(negedge mclk);
    check({1'b0, bridge_gnt, ext_gnt}, 8'h10);
    wr(`STTA_CTRL_OFFSET, 8'h80);
    repeat (2) @(negedge mclk);
    check({1'b0, bridge_gnt, ext_gnt}, 8'h40);
  endtask : t_park

  // Two high-tier masters alternate, bridge left low
  task automatic t_hi_rot();
    wr(`STTA_CTRL_OFFSET, 8'h12);
    grab(7'h12, 7'h02);
    grab(7'h12, 7'h10);
    grab(7'h12, 7'h02);
  endtask : t_hi_rot

  // Main sequence; idle bus parks on the bridge after reset
  initial begin
    repeat (4) @(negedge mclk);
    reset_n = 1'b1;
    repeat (2) @(negedge mclk);
    check({1'b0, bridge_gnt, ext_gnt}, 8'h40);
    t_regs();
    t_tiers();
    t_rotate();
    t_park();
    t_hi_rot();
    conclude();
  end
endmodule : tb
`default_nettype wire
